/* File: fracn_cfg_checker_assertions.sv */
// Port-level assertions for the divider and output configuration bank
`timescale 1ns/1ns
module fracn_cfg_checker (
  // Clock, reset, register port and phase sync mode input
  input logic        clock_i,
  input logic        rst_i,
  input logic [6:0]  addr_i,
  input logic [15:0] wdata_i,
  input logic        write_i,
  input logic        read_i,
  input logic [15:0] rdata_o,
  input logic        phase_sync_mode_i,
  // Modulator outputs
  input logic [31:0] modulator_seed_o,
  input logic        seed_load_o,
  input logic        fractional_active_o,
  input logic        modulator_hold_o,
  input logic [2:0]  modulator_order_o,
  input logic        order_reserved_o,
  // Output and pin decode
  input logic        output_a_enable_o,
  input logic [1:0]  output_a_source_o,
  input logic        output_a_hiz_o,
  input logic        input_pins_used_o,
  input logic        sync_lvds_o,
  input logic        request_lvds_o,
  input logic        input_pins_format_invalid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Read data shows zero unless a read came just before
  rdata_idle_a: assert property (!read_i |=> rdata_o == 16'h0)
    else $error("read data not zero without a read");
  // Written divider word reads back at once
  wr_rd_a: assert property (
    write_i && addr_i == 7'h24 ##1 read_i && addr_i == 7'h24 |=> rdata_o == $past(wdata_i, 2))
    else $error("divider low word read back wrong");
  // Seed write adds to the held seed
  seed_add_a: assert property (
    write_i && addr_i == 7'h29 && seed_load_o |=>
    modulator_seed_o == $past(modulator_seed_o) + {16'h0, $past(wdata_i)})
    else $error("seed write did not accumulate");
  // Held modulator keeps the seed cleared
  seed_clear_a: assert property (modulator_hold_o [*2] |-> modulator_seed_o == 32'h0)
    else $error("seed not cleared while modulator held");
  // Held modulator blocks fractional operation
  hold_blocks_a: assert property (
    modulator_hold_o |-> !fractional_active_o && !seed_load_o)
    else $error("fractional activity while held");
  // Nonzero order only in active fractional mode
  order_active_a: assert property (
    modulator_order_o != 3'h0 |-> fractional_active_o && !order_reserved_o)
    else $error("order shown outside fractional mode");
  // Reserved order codes give integer operation
  order_rsv_a: assert property (order_reserved_o |-> modulator_order_o == 3'h0)
    else $error("reserved order passed through");
  // High impedance source never drives output A
  a_hiz_a: assert property (
    output_a_hiz_o |-> output_a_source_o == 2'h3 && !output_a_enable_o)
    else $error("output A high impedance decode wrong");
  // Pins are used only in phase sync mode
  pins_used_a: assert property (input_pins_used_o |-> phase_sync_mode_i)
    else $error("input pins used outside phase sync mode");
  // Both pins LVDS is a valid format
  pin_fmt_a: assert property (
    sync_lvds_o && request_lvds_o |-> !input_pins_format_invalid_o)
    else $error("valid pin format flagged invalid");
  // Main scenarios reached
  cover property (write_i && addr_i == 7'h29 && seed_load_o);
  cover property (output_a_hiz_o);
  cover property (input_pins_used_o);
endmodule
bind fracn_divider_output_config_regs fracn_cfg_checker u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .phase_sync_mode_i(phase_sync_mode_i),
  .modulator_seed_o(modulator_seed_o), .seed_load_o(seed_load_o),
  .fractional_active_o(fractional_active_o), .modulator_hold_o(modulator_hold_o),
  .modulator_order_o(modulator_order_o), .order_reserved_o(order_reserved_o),
  .output_a_enable_o(output_a_enable_o), .output_a_source_o(output_a_source_o),
  .output_a_hiz_o(output_a_hiz_o), .input_pins_used_o(input_pins_used_o),
  .sync_lvds_o(sync_lvds_o), .request_lvds_o(request_lvds_o),
  .input_pins_format_invalid_o(input_pins_format_invalid_o));

/* File: fracn_cfg_map.vh */
// Register offsets, field positions, reset values for the divider/output config bank
`ifndef FRACN_CFG_MAP_VH
`define FRACN_CFG_MAP_VH
// Register indices (word addresses on the plain port)
`define ADDR_FB_DIV_HIGH      7'h22
`define ADDR_FB_DIV_LOW       7'h24
`define ADDR_SEED_EN_DLY      7'h25
`define ADDR_FRAC_DEN_HIGH    7'h26
`define ADDR_FRAC_DEN_LOW     7'h27
`define ADDR_SEED_HIGH        7'h28
`define ADDR_SEED_LOW         7'h29
`define ADDR_FRAC_NUM_HIGH    7'h2a
`define ADDR_FRAC_NUM_LOW     7'h2b
`define ADDR_OUT_PWR_MOD      7'h2c
`define ADDR_OUT_A_SRC        7'h2d
`define ADDR_OUT_B_SRC        7'h2e
`define ADDR_PIN_CFG          7'h3a
// Field positions
`define SEED_EN_BIT           15
`define DLY_SEL_LSB           8
`define OUT_A_PWR_LSB         8
`define OUT_B_PD_BIT          7
`define OUT_A_PD_BIT          6
`define MOD_RST_N_BIT         5
`define OUT_A_SRC_LSB         11
`define BOOST_LSB             9
`define PIN_IGNORE_BIT        15
`define PIN_HYST_BIT          14
`define PIN_LVL_LSB           12
`define PIN_FMT_LSB           9
// Reset values
`define RST_FB_DIV            19'h00064
`define RST_DLY_SEL           6'h02
`define RST_FRAC_DEN          32'hffffffff
`define RST_OUT_PWR           6'h1f
`define RST_SRC               2'h1
// Fixed patterns in the unused bits of the control words
`define FIX_SEED_EN_DLY       16'h0004
`define FIX_OUT_A_SRC         16'hc0c0
`define FIX_OUT_B_SRC         16'h07fc
`define FIX_PIN_CFG           16'h0001
// Modulator order codes
`define ORDER_INTEGER         3'h0
`define ORDER_MAX             3'h4
// Source select codes
`define SRC_CHAN_DIV          2'h0
`define SRC_OSC               2'h1
`define SRC_SYSREF            2'h2
`define SRC_HIZ               2'h3
`endif

/* File: fracn_divider_output_config_regs.v */
// Divider, modulator and output configuration register bank
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "fracn_cfg_map.vh"
module fracn_divider_output_config_regs (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // Register port
  input  wire [6:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        write_i,
  input  wire        read_i,
  output reg  [15:0] rdata_o,
  // External mode inputs
  input  wire        phase_sync_mode_i,
  input  wire        sysref_generator_enable_i,
  // Loop divider controls
  output wire [18:0] feedback_divider_o,
  output wire [5:0]  detector_delay_select_o,
  output wire [31:0] fraction_numerator_o,
  output wire [31:0] fraction_denominator_o,
  output wire        fractional_active_o,
  output wire [31:0] modulator_seed_o,
  output wire        seed_load_o,
  output wire [2:0]  modulator_order_o,
  output wire        order_reserved_o,
  output wire        modulator_hold_o,
  // Output ports
  output wire [5:0]  output_a_power_o,
  output wire [5:0]  output_b_power_o,
  output wire        output_a_enable_o,
  output wire        output_b_enable_o,
  output wire [1:0]  output_a_source_o,
  output wire [1:0]  output_b_source_o,
  output wire        output_a_hiz_o,
  output wire        output_b_hiz_o,
  output wire        source_select_fault_o,
  output wire [1:0]  output_current_boost_o,
  // Input pin configuration
  output wire        input_pins_used_o,
  output wire        sync_lvds_o,
  output wire        request_lvds_o,
  output wire        input_pins_format_invalid_o,
  output wire        input_pins_hysteresis_o,
  output wire [1:0]  input_pins_bias_level_o
);

  // Stored fields
  reg [2:0]  fb_div_high_r;          // Divider bits 18:16
  reg [15:0] fb_div_low_r;           // Divider bits 15:0
  // Seed enable and detector delay
  reg        modulator_seed_enable_r;
  reg [5:0]  detector_delay_select_r;
  // Fraction halves, joined high then low
  reg [31:0] fraction_denominator_r;
  reg [31:0] fraction_numerator_r;
  // Output power, powerdown and modulator control
  reg [5:0]  output_a_power_r;
  reg        output_b_powerdown_r;
  reg        output_a_powerdown_r;
  reg        modulator_reset_n_r;
  reg [2:0]  modulator_order_r;
  // Output sources, boost and output B power
  reg [1:0]  output_a_source_r;
  reg [1:0]  output_current_boost_r;
  reg [5:0]  output_b_power_r;
  reg [1:0]  output_b_source_r;
  // Input pin configuration fields
  reg        input_pins_disregard_r;
  reg        input_pins_hysteresis_r;
  reg [1:0]  input_pins_bias_level_r;
  reg [2:0]  input_pins_format_r;
  // Read path and accumulator result
  reg [15:0] rdata_nxt;              // Read mux result
  wire [31:0] seed_w;                // Accumulated seed

  // Per-address write strobes
  // Seed words go to the accumulator, not the field process
  wire wr_seed_hi = write_i & (addr_i == `ADDR_SEED_HIGH);
  wire wr_seed_lo = write_i & (addr_i == `ADDR_SEED_LOW);

  // Register writes
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      // Divider, delay and fraction defaults
      {fb_div_high_r, fb_div_low_r} <= `RST_FB_DIV;
      modulator_seed_enable_r <= 1'b0;
      detector_delay_select_r <= `RST_DLY_SEL;
      fraction_denominator_r  <= `RST_FRAC_DEN;
      fraction_numerator_r    <= 32'h00000000;
      // Output power and modulator defaults
      output_a_power_r        <= `RST_OUT_PWR;
      output_b_powerdown_r    <= 1'b1;
      output_a_powerdown_r    <= 1'b0;
      modulator_reset_n_r     <= 1'b1;
      modulator_order_r       <= `ORDER_INTEGER;
      // Source, boost and output B defaults
      output_a_source_r       <= `RST_SRC;
      output_current_boost_r  <= 2'h0;
      output_b_power_r        <= `RST_OUT_PWR;
      output_b_source_r       <= `RST_SRC;
      // Input pins ignored until software enables them
      input_pins_disregard_r  <= 1'b1;
      input_pins_hysteresis_r <= 1'b0;
      input_pins_bias_level_r <= 2'h0;
      input_pins_format_r     <= 3'h0;
    end else if (write_i) begin
      // Seed and unmapped indices fall through to default
      case (addr_i)
        // Divider upper bits
        `ADDR_FB_DIV_HIGH: begin
          fb_div_high_r <= wdata_i[2:0];
        end
        // Divider lower bits
        `ADDR_FB_DIV_LOW: begin
          fb_div_low_r <= wdata_i;
        end
        // Seed enable and detector delay
        `ADDR_SEED_EN_DLY: begin
          modulator_seed_enable_r <= wdata_i[`SEED_EN_BIT];
          detector_delay_select_r <= wdata_i[`DLY_SEL_LSB +: 6];
        end
        // Upper denominator half
        `ADDR_FRAC_DEN_HIGH: begin
          fraction_denominator_r[31:16] <= wdata_i;
        end
        // Lower denominator half
        `ADDR_FRAC_DEN_LOW: begin
          fraction_denominator_r[15:0] <= wdata_i;
        end
        // Upper numerator half
        `ADDR_FRAC_NUM_HIGH: begin
          fraction_numerator_r[31:16] <= wdata_i;
        end
        // Lower numerator half
        `ADDR_FRAC_NUM_LOW: begin
          fraction_numerator_r[15:0] <= wdata_i;
        end
        // Power, powerdown and modulator control
        `ADDR_OUT_PWR_MOD: begin
          output_a_power_r     <= wdata_i[`OUT_A_PWR_LSB +: 6];
          output_b_powerdown_r <= wdata_i[`OUT_B_PD_BIT];
          output_a_powerdown_r <= wdata_i[`OUT_A_PD_BIT];
          modulator_reset_n_r  <= wdata_i[`MOD_RST_N_BIT];
          modulator_order_r    <= wdata_i[2:0];
        end
        // Output A source, boost, output B power
        `ADDR_OUT_A_SRC: begin
          output_a_source_r      <= wdata_i[`OUT_A_SRC_LSB +: 2];
          output_current_boost_r <= wdata_i[`BOOST_LSB +: 2];
          output_b_power_r       <= wdata_i[5:0];
        end
        // Output B source
        `ADDR_OUT_B_SRC: begin
          output_b_source_r <= wdata_i[1:0];
        end
        // Input pin configuration
        `ADDR_PIN_CFG: begin
          input_pins_disregard_r  <= wdata_i[`PIN_IGNORE_BIT];
          input_pins_hysteresis_r <= wdata_i[`PIN_HYST_BIT];
          input_pins_bias_level_r <= wdata_i[`PIN_LVL_LSB +: 2];
          input_pins_format_r     <= wdata_i[`PIN_FMT_LSB +: 3];
        end
        // Seed handled elsewhere; unmapped addresses change nothing
        default: begin
          input_pins_format_r <= input_pins_format_r;
        end
      endcase
    end
  end

  // Seed accumulates on writes; cleared while modulator held in reset
  // Clear beats add, so a held modulator pins the seed at zero
  // Both halves share the write data bus
  seed_accum u_seed (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .clear_i  (~modulator_reset_n_r),
    .add_hi_i (wr_seed_hi),
    .add_lo_i (wr_seed_lo),
    .data_i   (wdata_i),
    .seed_o   (seed_w)
  );

  // Read mux; fixed pattern bits read back as stored pattern
  always @* begin
    rdata_nxt = 16'h0000;
    case (addr_i)
      // Divider upper bits, rest of the word reads zero
      `ADDR_FB_DIV_HIGH: begin
        rdata_nxt = {13'h0000, fb_div_high_r};
      end
      // Divider lower bits
      `ADDR_FB_DIV_LOW: begin
        rdata_nxt = fb_div_low_r;
      end
      // Seed enable, delay select and the fixed bit
      `ADDR_SEED_EN_DLY: begin
        rdata_nxt = {modulator_seed_enable_r, 1'b0, detector_delay_select_r, 8'h00}
                    | `FIX_SEED_EN_DLY;
      end
      // Denominator halves
      `ADDR_FRAC_DEN_HIGH: begin
        rdata_nxt = fraction_denominator_r[31:16];
      end
      `ADDR_FRAC_DEN_LOW: begin
        rdata_nxt = fraction_denominator_r[15:0];
      end
      // Accumulated seed halves, enabled or not
      `ADDR_SEED_HIGH: begin
        rdata_nxt = seed_w[31:16];
      end
      `ADDR_SEED_LOW: begin
        rdata_nxt = seed_w[15:0];
      end
      // Numerator halves as stored, not as gated
      `ADDR_FRAC_NUM_HIGH: begin
        rdata_nxt = fraction_numerator_r[31:16];
      end
      `ADDR_FRAC_NUM_LOW: begin
        rdata_nxt = fraction_numerator_r[15:0];
      end
      // Power, powerdown and modulator control
      `ADDR_OUT_PWR_MOD: begin
        rdata_nxt = {2'h0, output_a_power_r, output_b_powerdown_r,
                     output_a_powerdown_r, modulator_reset_n_r,
                     2'h0, modulator_order_r};
      end
      // Output A source, boost and output B power
      `ADDR_OUT_A_SRC: begin
        rdata_nxt = {3'h0, output_a_source_r, output_current_boost_r,
                     3'h0, output_b_power_r} | `FIX_OUT_A_SRC;
      end
      // Output B source under its fixed ones
      `ADDR_OUT_B_SRC: begin
        rdata_nxt = {14'h0000, output_b_source_r} | `FIX_OUT_B_SRC;
      end
      // Input pin configuration
      `ADDR_PIN_CFG: begin
        rdata_nxt = {input_pins_disregard_r, input_pins_hysteresis_r,
                     input_pins_bias_level_r, input_pins_format_r,
                     9'h000} | `FIX_PIN_CFG;
      end
      // Unmapped reads return zero
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  // Read data registered, stands one cycle after the strobe
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (read_i) begin
      // Capture the mux on a read strobe
      rdata_o <= rdata_nxt;
    end else begin
      // Zero whenever no read was taken
      rdata_o <= 16'h0000;
    end
  end

  // Loop divider outputs
  // Divider joins upper and lower words
  assign feedback_divider_o      = {fb_div_high_r, fb_div_low_r};
  // Delay select is software's to match the divider
  assign detector_delay_select_o = detector_delay_select_r;
  // Hold follows the active-low modulator reset bit
  assign modulator_hold_o        = ~modulator_reset_n_r;
  // Codes above four are reserved
  assign order_reserved_o        = modulator_order_r > `ORDER_MAX;
  // Fractional path only with a valid nonzero order and no hold
  assign fractional_active_o     = modulator_reset_n_r & ~order_reserved_o
                                   & (modulator_order_r != `ORDER_INTEGER);
  // Order shown only while the fractional path runs
  assign modulator_order_o       = fractional_active_o ? modulator_order_r
                                                       : `ORDER_INTEGER;
  // Numerator forced to zero when not active
  assign fraction_numerator_o    = fractional_active_o ? fraction_numerator_r
                                                       : 32'h00000000;
  // Denominator passes through unchanged
  assign fraction_denominator_o  = fraction_denominator_r;
  // Seed reaches the modulator only when enabled
  assign modulator_seed_o        = modulator_seed_enable_r ? seed_w : 32'h00000000;
  // Load only for a running fractional path
  assign seed_load_o             = modulator_seed_enable_r & fractional_active_o;

  // Output drive controls
  // Power codes pass through as stored
  assign output_a_power_o        = output_a_power_r;
  assign output_b_power_o        = output_b_power_r;
  // Code 3 floats the port
  assign output_a_hiz_o          = output_a_source_r == `SRC_HIZ;
  assign output_b_hiz_o          = output_b_source_r == `SRC_HIZ;
  // Output A off for powerdown, reserved or floating code
  assign output_a_enable_o       = ~output_a_powerdown_r & ~output_a_hiz_o
                                   & (output_a_source_r != `SRC_SYSREF);
  // Output B has no reserved code
  assign output_b_enable_o       = ~output_b_powerdown_r & ~output_b_hiz_o;
  // Source codes as stored
  assign output_a_source_o       = output_a_source_r;
  assign output_b_source_o       = output_b_source_r;
  // Flags reserved A code, or sysref chosen without generator enabled
  assign source_select_fault_o   = (output_a_source_r == `SRC_SYSREF)
                                   | ((output_b_source_r == `SRC_SYSREF)
                                      & ~sysref_generator_enable_i);
  // Boost code, zero gives the most boost
  assign output_current_boost_o  = output_current_boost_r;

  // Input pin configuration decode
  pin_decode u_pins (
    .disregard_i       (input_pins_disregard_r),
    .phase_sync_mode_i (phase_sync_mode_i),
    .format_i          (input_pins_format_r),
    .pins_used_o       (input_pins_used_o),
    .sync_lvds_o       (sync_lvds_o),
    .request_lvds_o    (request_lvds_o),
    .format_invalid_o  (input_pins_format_invalid_o)
  );
  // Hysteresis and bias level pass straight through
  assign input_pins_hysteresis_o = input_pins_hysteresis_r;
  assign input_pins_bias_level_o = input_pins_bias_level_r;

endmodule

/* File: fracn_divider_output_config_regs_tb_top.sv */
// Self-checking bench for the divider and output configuration bank
`timescale 1ns/1ns
module fracn_divider_output_config_regs_tb_top;
  logic        clock_i, rst_i, write_i, read_i, psm, gen_en;  // Drives and mode inputs
  logic [6:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [18:0] fb;                                           // Observed outputs
  logic [5:0]  dly, apw, bpw;
  logic [31:0] num, den, sd;
  logic [2:0]  ord;
  logic [1:0]  asrc, bsrc, boost, lvl;
  logic        act, sld, rsv, hold, aen, ben, ahiz, bhiz, flt, used, slv, rlv, inv, hyst;
  logic [15:0] st [0:127];                                   // Shadow of stored bits
  logic [31:0] seed_m;                                       // Expected accumulated seed
  integer      err_count, compares, seed, i, k;
  // Mapped registers then three unmapped indices
  localparam logic [6:0] addr_tab [16] = '{7'h22, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29,
    7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h3a, 7'h23, 7'h30, 7'h7f};
  // Hand-written cases: read flag, index, data
  localparam logic [23:0] corner_tab [15] = '{24'h258000, 24'h2c0022, 24'h29ffff, 24'h290001,
    24'h28ffff, 24'h280001, 24'h241234, 24'ha40000, 24'h2c0002, 24'h290005, 24'h2c0022,
    24'h290007, 24'h250000, 24'h230abc, 24'ha30000};
  fracn_divider_output_config_regs DUT (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
    .read_i(read_i), .rdata_o(rdata_o), .phase_sync_mode_i(psm),
    .sysref_generator_enable_i(gen_en), .feedback_divider_o(fb), .detector_delay_select_o(dly),
    .fraction_numerator_o(num), .fraction_denominator_o(den), .fractional_active_o(act),
    .modulator_seed_o(sd), .seed_load_o(sld), .modulator_order_o(ord), .order_reserved_o(rsv),
    .modulator_hold_o(hold), .output_a_power_o(apw), .output_b_power_o(bpw),
    .output_a_enable_o(aen), .output_b_enable_o(ben), .output_a_source_o(asrc),
    .output_b_source_o(bsrc), .output_a_hiz_o(ahiz), .output_b_hiz_o(bhiz),
    .source_select_fault_o(flt), .output_current_boost_o(boost), .input_pins_used_o(used),
    .sync_lvds_o(slv), .request_lvds_o(rlv), .input_pins_format_invalid_o(inv),
    .input_pins_hysteresis_o(hyst), .input_pins_bias_level_o(lvl));
  // Clock at 100 MHz
  always #5 clock_i = ~clock_i;
  // Stored bits of each register
  function automatic logic [15:0] mask_of(input logic [6:0] a);
    case (a)
      7'h22: mask_of = 16'h0007;
      7'h25: mask_of = 16'hbf00;
      7'h2c: mask_of = 16'h3fe7;
      7'h2d: mask_of = 16'h1e3f;
      7'h2e: mask_of = 16'h0003;
      7'h3a: mask_of = 16'hfe00;
      7'h24, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2b: mask_of = 16'hffff;
      default: mask_of = 16'h0000;
    endcase
  endfunction
  // Fixed pattern bits, then readback after reset
  function automatic logic [15:0] fix_of(input logic [6:0] a, input logic r);
    case (a)
      7'h24: fix_of = r ? 16'h0064 : 16'h0;
      7'h25: fix_of = r ? 16'h0204 : 16'h0004;
      7'h26, 7'h27: fix_of = r ? 16'hffff : 16'h0;
      7'h2c: fix_of = r ? 16'h1fa0 : 16'h0;
      7'h2d: fix_of = r ? 16'hc8df : 16'hc0c0;
      7'h2e: fix_of = r ? 16'h07fd : 16'h07fc;
      7'h3a: fix_of = r ? 16'h8001 : 16'h0001;
      default: fix_of = 16'h0000;
    endcase
  endfunction
  // Count and report one comparison
  task automatic cmp(input logic [157:0] got, input logic [157:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every configuration output against the shadow
  task automatic check_outs;
    logic [15:0] c, d, e, p;
    logic [2:0]  f;
    logic        a;
    c = st[7'h2c];
    d = st[7'h2d];
    e = st[7'h2e];
    p = st[7'h3a];
    f = p[11:9];
    a = c[5] && c[2:0] != 3'h0 && c[2:0] < 3'h5;
    cmp({fb, dly, num, den, act, sd, sld, ord, rsv, hold, apw, bpw, aen, ben, asrc, bsrc, ahiz,
      bhiz, flt, boost, used, slv, rlv, inv, hyst, lvl}, {st[7'h22][2:0], st[7'h24],
      st[7'h25][13:8], a ? {st[7'h2a], st[7'h2b]} : 32'h0, st[7'h26], st[7'h27], a,
      st[7'h25][15] ? seed_m : 32'h0, st[7'h25][15] & a, a ? c[2:0] : 3'h0, c[2:0] > 3'h4,
      !c[5], c[13:8], d[5:0], !c[6] && d[12:11] < 2'h2, !c[7] && e[1:0] != 2'h3, d[12:11],
      e[1:0], d[12:11] == 2'h3, e[1:0] == 2'h3, d[12:11] == 2'h2 || e[1:0] == 2'h2 && !gen_en,
      d[10:9], !p[15] && psm, f == 3'h1 || f == 3'h3, f == 3'h2 || f == 3'h3, f > 3'h3,
      p[14], p[13:12]});
  endtask
  // One bus cycle, then model the taking edge and check
  task automatic op(input logic w, input logic r, input logic [6:0] a, input logic [15:0] d);
    logic [15:0] e;
    write_i <= w;
    read_i <= r;
    addr_i <= a;
    wdata_i <= d;
    e = r ? (st[a] & mask_of(a)) | fix_of(a, 1'b0) : 16'h0;
    if (r && a == 7'h28) e = seed_m[31:16];
    if (r && a == 7'h29) e = seed_m[15:0];
    @(posedge clock_i);
    if (!st[7'h2c][5]) seed_m = 32'h0;
    else if (w && a == 7'h28) seed_m = seed_m + {d, 16'h0};
    else if (w && a == 7'h29) seed_m = seed_m + {16'h0, d};
    if (w) st[a] = d;
    #1;
    cmp({142'h0, rdata_o}, {142'h0, e});
    check_outs;
  endtask
  // Verdict and end of run
  task automatic test_done;
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {clock_i, write_i, read_i, psm, gen_en, addr_i, wdata_i} = '0;
    {err_count, compares, seed_m} = '0;
    rst_i = 1'b1;
    seed = 16;
    for (i = 0; i < 128; i++) st[i] = fix_of(i[6:0], 1'b1) & mask_of(i[6:0]);
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    for (i = 0; i < 16; i++) op(1'b0, 1'b1, addr_tab[i], 16'h0);
    for (i = 0; i < 15; i++) begin
      k = corner_tab[i];
      op(!k[23], k[23], k[22:16], k[15:0]);
    end
    for (i = 0; i < 8; i++) begin
      psm <= i[1];
      gen_en <= i[2];
      op(1'b1, 1'b0, 7'h2c, {13'h4, i[2:0]});
      op(1'b1, 1'b0, 7'h2d, {3'h0, i[1:0], i[1:0], 9'h0});
      op(1'b1, 1'b0, 7'h2e, {14'h0, i[1:0]});
      op(1'b1, 1'b0, 7'h3a, {~i[0], 3'h0, i[2:0], 9'h0});
    end
    for (i = 0; i < 500; i++) begin
      k = $random(seed);
      psm <= k[8];
      gen_en <= k[9];
      op(k[1], !k[1], addr_tab[k[7:4]], 16'($random(seed)));
    end
    test_done;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    err_count++;
    test_done;
  end
endmodule

/* File: pin_decode.v */
// Decoder for the sync and sysref request pin configuration
`timescale 1ns/1ns
module pin_decode (
  // Configuration
  input  wire       disregard_i,
  input  wire       phase_sync_mode_i,
  input  wire [2:0] format_i,
  // Decoded controls
  output wire       pins_used_o,
  output wire       sync_lvds_o,
  output wire       request_lvds_o,
  output wire       format_invalid_o
);

  // Pins only used when not disregarded and phase sync mode on
  assign pins_used_o      = ~disregard_i & phase_sync_mode_i;
  // Bit 0 of format selects LVDS sync, bit 1 request pin
  assign format_invalid_o = format_i[2];
  assign sync_lvds_o      = ~format_i[2] & format_i[0];
  assign request_lvds_o   = ~format_i[2] & format_i[1];

endmodule

/* File: seed_accum.v */
// Accumulating 32-bit modulator seed register
`timescale 1ns/1ns
module seed_accum (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // Write controls
  input  wire        clear_i,   // Modulator reset clears seed
  input  wire        add_hi_i,  // Add into upper half
  input  wire        add_lo_i,  // Add into lower half
  input  wire [15:0] data_i,
  // Accumulated seed
  output reg  [31:0] seed_o
);

  // Adds each write rather than replacing; clear has priority
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      seed_o <= 32'h00000000;
    end else if (clear_i) begin
      seed_o <= 32'h00000000;
    end else if (add_hi_i) begin
      seed_o <= seed_o + {data_i, 16'h0000};
    end else if (add_lo_i) begin
      seed_o <= seed_o + {16'h0000, data_i};
    end
  end

endmodule
